// >>> rtl/luc_regs.svh
// Purpose: register offsets, field positions and reset values of the limited counter
// Assumes: byte addresses on a 32-bit classic Wishbone slave
// Notes: definitions only
`ifndef LUC_REGS_SVH
`define LUC_REGS_SVH

// offsets
`define LUC_OFF_CTRL 8'h00
`define LUC_OFF_PRESET 8'h04
`define LUC_OFF_UPPER 8'h08
`define LUC_OFF_LOWER 8'h0C
`define LUC_OFF_COUNT 8'h10
`define LUC_OFF_FLAGS 8'h14
`define LUC_OFF_IRQ_STAT 8'h18
`define LUC_OFF_IRQ_MASK 8'h1C
`define LUC_OFF_PASS_DIV 8'h20

// field positions
`define LUC_CTRL_WRAP 0
`define LUC_FLAG_UPPER 0
`define LUC_FLAG_LOWER 1
`define LUC_FLAG_ZERO 2
`define LUC_EVT_W 3

// reset values
`define LUC_RST_WRAP 1'b0
`define LUC_RST_EVT 3'h0
`define LUC_RST_PASS_DIV 16'h0000

`endif

// >>> rtl/luc_pkg.sv
// Purpose: shared types of the limited counter
// Assumes: used as luc_pkg::name, never imported
// Notes: none
`default_nettype none

package luc_pkg;
	// first pass samples the pulse inputs but counts no edge
	typedef enum logic {LUC_INIT, LUC_RUN} luc_phase_t;
endpackage

`default_nettype wire

// >>> rtl/luc_counter.sv
// Purpose: bounded up/down counter evaluated once per cyclic pass
// Assumes: pulse and control inputs come from logic on ref_clk
// Notes: registers over classic Wishbone, one level interrupt
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`include "luc_regs.svh"
`default_nettype none

module luc_counter #(
	parameter int W = 16,
	parameter int DIV_W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// upstream control
	input wire logic up_pulse_in,
	input wire logic down_pulse_in,
	input wire logic clear_in,
	input wire logic preset_in,
	// results
	output logic signed [W-1:0] count_out,
	output logic at_upper_flag,
	output logic at_lower_flag,
	output logic zero_flag,
	output logic pass_tick,
	output logic irq_out
);

	// ****************************************
	// parameter checks
	// ****************************************
	generate
		if (W < 2 || W > 31 || DIV_W < 1 || DIV_W > 32)
		begin : g_bad_param
			$error("luc_counter: W must be 2..31 and DIV_W 1..32");
		end
	endgenerate

	localparam logic signed [W-1:0] ONE = W'(1);
	localparam logic signed [W-1:0] ZERO = '0;
	localparam int PADW = 32 - W;

	function automatic logic signed [W-1:0] clampW(
		input logic signed [W-1:0] v,
		input logic signed [W-1:0] lo,
		input logic signed [W-1:0] hi
	);
		clampW = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [31:0] byteMerge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] sel
	);
		for (int i = 0; i < 4; i++)
		begin
			byteMerge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic ackQ;
	logic [31:0] datQ;
	logic wrapQ;
	logic signed [W-1:0] presetQ;
	logic signed [W-1:0] upperQ;
	logic signed [W-1:0] lowerQ;
	logic [DIV_W-1:0] passDivQ;
	logic [DIV_W-1:0] divCntQ;
	logic tickQ;
	luc_pkg::luc_phase_t phaseQ;
	logic upPrevQ;
	logic downPrevQ;
	logic signed [W-1:0] countQ;
	logic atUpperQ;
	logic atLowerQ;
	logic zeroQ;
	logic [`LUC_EVT_W-1:0] statQ;
	logic [`LUC_EVT_W-1:0] maskQ;
	logic irqQ;

	// ****************************************
	// bus decode
	// ****************************************
	wire busReq = wb_cyc_i & wb_stb_i & ~ackQ;
	wire busWr = busReq & wb_we_i;
	wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
	wire selCtrl = adr == `LUC_OFF_CTRL;
	wire selPreset = adr == `LUC_OFF_PRESET;
	wire selUpper = adr == `LUC_OFF_UPPER;
	wire selLower = adr == `LUC_OFF_LOWER;
	wire selCount = adr == `LUC_OFF_COUNT;
	wire selFlags = adr == `LUC_OFF_FLAGS;
	wire selStat = adr == `LUC_OFF_IRQ_STAT;
	wire selMask = adr == `LUC_OFF_IRQ_MASK;
	wire selDiv = adr == `LUC_OFF_PASS_DIV;

	wire [31:0] presetRd = {{PADW{1'b0}}, presetQ};
	wire [31:0] upperRd = {{PADW{1'b0}}, upperQ};
	wire [31:0] lowerRd = {{PADW{1'b0}}, lowerQ};
	wire [31:0] countRd = {{PADW{1'b0}}, countQ};
	wire [31:0] divRd = 32'(passDivQ);
	wire [31:0] flagsRd = {29'h0, zeroQ, atLowerQ, atUpperQ};
	wire [31:0] statRd = {29'h0, statQ};
	wire [31:0] maskRd = {29'h0, maskQ};

	// unmapped reads answer zero
	wire [31:0] rdData =
		selCtrl ? {31'h0, wrapQ} :
		selPreset ? presetRd :
		selUpper ? upperRd :
		selLower ? lowerRd :
		selCount ? countRd :
		selFlags ? flagsRd :
		selStat ? statRd :
		selMask ? maskRd :
		selDiv ? divRd : 32'h0;

	wire [31:0] presetWr = byteMerge(presetRd, wb_dat_i, wb_sel_i);
	wire [31:0] upperWr = byteMerge(upperRd, wb_dat_i, wb_sel_i);
	wire [31:0] lowerWr = byteMerge(lowerRd, wb_dat_i, wb_sel_i);
	wire [31:0] divWr = byteMerge(divRd, wb_dat_i, wb_sel_i);
	wire [`LUC_EVT_W-1:0] statClr =
		(busWr & selStat & wb_sel_i[0]) ? wb_dat_i[`LUC_EVT_W-1:0] : `LUC_RST_EVT;

	// ****************************************
	// pass divider
	// ****************************************
	wire divWrap = divCntQ >= passDivQ;
	wire [DIV_W-1:0] divCntD = divWrap ? '0 : divCntQ + DIV_W'(1);

	// ****************************************
	// pass evaluation
	// ****************************************
	// edge is high this pass, low last
	// no edges during the first pass
	wire running = phaseQ == luc_pkg::LUC_RUN;
	wire upEdge = running & up_pulse_in & ~upPrevQ;
	wire downEdge = running & down_pulse_in & ~downPrevQ;
	wire upOnly = upEdge & ~downEdge;
	wire downOnly = downEdge & ~upEdge;
	wire lowOk = lowerQ < upperQ;
	wire atTop = countQ >= upperQ;
	wire atBottom = countQ <= lowerQ;
	wire counting = lowOk & ~clear_in & ~preset_in;

	wire wrapUp = wrapQ & counting & upOnly & atTop;
	wire wrapDown = wrapQ & counting & downOnly & atBottom;

	wire signed [W-1:0] upVal = atTop ? (wrapQ ? lowerQ : upperQ) : countQ + ONE;
	wire signed [W-1:0] downVal = atBottom ? (wrapQ ? upperQ : lowerQ) : countQ - ONE;
	wire signed [W-1:0] stepped = upOnly ? upVal : (downOnly ? downVal : countQ);

	// zero pulled into the bounds under clear
	wire signed [W-1:0] clearVal = clampW(ZERO, lowerQ, upperQ);
	// bad bounds force upper; else clamp
	wire signed [W-1:0] countD =
		!lowOk ? upperQ :
		clear_in ? clearVal :
		preset_in ? clampW(presetQ, lowerQ, upperQ) :
		clampW(stepped, lowerQ, upperQ);

	wire atUpperD = wrapQ ? wrapUp : (countD == upperQ);
	wire atLowerD = wrapQ ? wrapDown : (countD == lowerQ);
	wire zeroD = countD == ZERO;

	// interrupt events on flag rise, every overflow in wrap mode
	wire [`LUC_EVT_W-1:0] evt = {`LUC_EVT_W{tickQ}} & {
		zeroD & ~zeroQ,
		atLowerD & (~atLowerQ | wrapQ),
		atUpperD & (~atUpperQ | wrapQ)};
	// a new event wins over a clear in the same cycle
	wire [`LUC_EVT_W-1:0] statD = (statQ & ~statClr) | evt;

	// ****************************************
	// wishbone registers
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			ackQ <= 1'b0;
			datQ <= 32'h0;
		end
		else
		begin
			ackQ <= busReq;
			datQ <= busReq ? rdData : datQ;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			wrapQ <= `LUC_RST_WRAP;
			presetQ <= ZERO;
			upperQ <= ZERO;
			lowerQ <= ZERO;
			passDivQ <= DIV_W'(`LUC_RST_PASS_DIV);
			maskQ <= `LUC_RST_EVT;
		end
		else if (busWr)
		begin
			if (selCtrl && wb_sel_i[0])
				wrapQ <= wb_dat_i[`LUC_CTRL_WRAP];
			if (selPreset)
				presetQ <= presetWr[W-1:0];
			if (selUpper)
				upperQ <= upperWr[W-1:0];
			if (selLower)
				lowerQ <= lowerWr[W-1:0];
			if (selDiv)
				passDivQ <= divWr[DIV_W-1:0];
			if (selMask && wb_sel_i[0])
				maskQ <= wb_dat_i[`LUC_EVT_W-1:0];
		end
	end

	// ****************************************
	// pass tick
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			divCntQ <= '0;
			tickQ <= 1'b0;
		end
		else
		begin
			divCntQ <= divCntD;
			tickQ <= divWrap;
		end
	end

	// ****************************************
	// counter core
	// ****************************************
	// reset state is the first pass start state
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			phaseQ <= luc_pkg::LUC_INIT;
			upPrevQ <= 1'b0;
			downPrevQ <= 1'b0;
			countQ <= ZERO;
			atUpperQ <= 1'b0;
			atLowerQ <= 1'b0;
			zeroQ <= 1'b0;
		end
		else if (tickQ)
		begin
			phaseQ <= luc_pkg::LUC_RUN;
			upPrevQ <= up_pulse_in;
			downPrevQ <= down_pulse_in;
			countQ <= countD;
			atUpperQ <= atUpperD;
			atLowerQ <= atLowerD;
			zeroQ <= zeroD;
		end
	end

	// ****************************************
	// interrupt
	// ****************************************
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			statQ <= `LUC_RST_EVT;
			irqQ <= 1'b0;
		end
		else
		begin
			statQ <= statD;
			irqQ <= |(statD & maskQ);
		end
	end

	assign wb_ack_o = ackQ;
	assign wb_dat_o = datQ;
	assign count_out = countQ;
	assign at_upper_flag = atUpperQ;
	assign at_lower_flag = atLowerQ;
	assign zero_flag = zeroQ;
	assign pass_tick = tickQ;
	assign irq_out = irqQ;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	wire inRange = countQ >= lowerQ && countQ < upperQ;
	wire quiet = tickQ & lowOk & ~clear_in & ~preset_in;

	sequence sWrapUpCause;
		quiet & running & wrapQ & upOnly & (countQ == upperQ);
	endsequence
	sequence sWrapDownCause;
		quiet & running & wrapQ & downOnly & (countQ == lowerQ);
	endsequence

	a_up_step: assert property (
		quiet & upOnly & inRange |=> countQ == $past(countQ) + ONE)
		else $error("up edge did not add one");
	a_down_step: assert property (
		quiet & downOnly & countQ > lowerQ & countQ <= upperQ
		|=> countQ == $past(countQ) - ONE)
		else $error("down edge did not subtract one");
	a_preset_load: assert property (
		tickQ & lowOk & preset_in & ~clear_in & presetQ >= lowerQ & presetQ <= upperQ
		|=> countQ == $past(presetQ))
		else $error("preset not loaded");
	a_clear_zero: assert property (
		tickQ & lowOk & clear_in & lowerQ <= ZERO & upperQ >= ZERO
		|=> countQ == ZERO)
		else $error("clear did not hold zero");
	a_clear_bound: assert property (
		tickQ & lowOk & clear_in & lowerQ > ZERO |=> countQ == $past(lowerQ))
		else $error("clear outside range missed bound");
	a_stop_upper: assert property (
		quiet & running & ~wrapQ & upOnly & (countQ == upperQ)
		|=> countQ == $past(countQ) && atUpperQ)
		else $error("stop mode left upper bound");
	a_wrap_up: assert property (
		sWrapUpCause |=> countQ == $past(lowerQ) && atUpperQ)
		else $error("upward wrap wrong");
	// overflow flag must drop at the next pass unless a new wrap follows
	a_wrap_pulse: assert property (
		tickQ & wrapQ & atUpperQ & ~upOnly |=> !atUpperQ)
		else $error("overflow flag held past one pass");
	a_wrap_down: assert property (
		sWrapDownCause |=> countQ == $past(upperQ) && atLowerQ)
		else $error("downward wrap wrong");
	a_zero_flag: assert property (
		zeroQ == (countQ == ZERO) || phaseQ == luc_pkg::LUC_INIT)
		else $error("zero flag disagrees with count");
	a_first_pass: assert property (
		quiet & ~running & inRange |=> countQ == $past(countQ))
		else $error("edge seen in first pass");
	a_bad_bounds: assert property (
		tickQ & ~lowOk |=> countQ == $past(upperQ))
		else $error("bad bounds did not force upper");
	a_pass_edge: assert property (
		tickQ |=> upPrevQ == $past(up_pulse_in) && downPrevQ == $past(down_pulse_in))
		else $error("edge sample not taken on tick");
	a_irq_level: assert property (
		|(statQ & maskQ) |-> ##[0:1] irqQ)
		else $error("interrupt missing");

endmodule

`default_nettype wire

// >>> verif/luc_pulse_src.sv
// Purpose: upstream logic model driving the counter's control pins
// Assumes: the bench asks for one command at a time
// Notes: each command is held three cycles so it spans a pass
`default_nettype none

module luc_pulse_src (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// command from bench: up, down, clear, preset
	input wire logic [3:0] cmdReq,
	// pins toward the counter
	output logic upPulse,
	output logic downPulse,
	output logic clearLvl,
	output logic presetLvl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] hold_q;
	logic [3:0] pins_q;
	// levels outlast a tick, then fall, so each pulse is one edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			hold_q <= 2'h0;
			pins_q <= 4'h0;
		end
		else if (cmdReq != 4'h0)
		begin
			hold_q <= 2'h2;
			pins_q <= cmdReq;
		end
		else if (hold_q != 2'h0)
			hold_q <= hold_q - 2'h1;
		else
			pins_q <= 4'h0;
	end
	assign upPulse = pins_q[0];
	assign downPulse = pins_q[1];
	assign clearLvl = pins_q[2];
	assign presetLvl = pins_q[3];
endmodule

`default_nettype wire

// >>> verif/test_luc_counter.sv
// Purpose: self-checking bench of the limited counter
// Assumes: pass divider left at 0 until t_divider sets it to 2, so every cycle is a pass until then
// Notes: pins driven through the upstream model
`include "luc_regs.svh"
`default_nettype none

module test_luc_counter;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic sysRst = 1'b1;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00;
	logic [31:0] wbDat = 32'h0;
	logic [31:0] rdData;
	logic wbAck;
	logic [3:0] cmd = 4'h0;
	logic upP, dnP, clrL, preL;
	logic signed [15:0] cnt;
	logic fUp, fLo, fZero, tick, irq;
	int errCount = 0;
	int checked = 0;

	always #5 ref_clk = ~ref_clk;

	luc_pulse_src src (.ref_clk(ref_clk), .sys_rst(sysRst), .cmdReq(cmd), .upPulse(upP),
		.downPulse(dnP), .clearLvl(clrL), .presetLvl(preL));

	luc_counter uut (.ref_clk(ref_clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
		.wb_dat_o(rdData), .wb_ack_o(wbAck), .up_pulse_in(upP), .down_pulse_in(dnP),
		.clear_in(clrL), .preset_in(preL), .count_out(cnt), .at_upper_flag(fUp),
		.at_lower_flag(fLo), .zero_flag(fZero), .pass_tick(tick), .irq_out(irq));

	task automatic print_verdict();
		$display("checks %0d errors %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// holds the request until ack is sampled, then releases for a cycle
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		wbWe <= we;
		wbAdr <= a;
		wbDat <= d;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		@(posedge ref_clk);
		while (wbAck !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge ref_clk);
		end
		q = rdData;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge ref_clk);
		if (n == 50)
			chk("ack", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask

	task automatic pin(input logic [3:0] c, input int reps);
		repeat (reps)
		begin
			cmd <= c;
			@(posedge ref_clk);
			cmd <= 4'h0;
			repeat (6) @(posedge ref_clk);
		end
	endtask

	task automatic pins(input string nm, input logic [15:0] c, input logic [2:0] f);
		chk(nm, {16'h0, c}, {16'h0, cnt});
		chk({nm, " flags"}, {29'h0, f}, {29'h0, fZero, fLo, fUp});
	endtask

	task automatic t_reset();
		rd("ctrl", `LUC_OFF_CTRL, 32'h0);
		rd("preset", `LUC_OFF_PRESET, 32'h0);
		rd("mask", `LUC_OFF_IRQ_MASK, 32'h0);
		rd("unmapped", 8'h24, 32'h0);
		pins("bad bounds", 16'h0000, 3'b111);
	endtask

	task automatic t_count();
		wr(`LUC_OFF_UPPER, 32'h2);
		wr(`LUC_OFF_LOWER, 32'hFFFE);
		pin(4'h1, 3);
		pins("up stop", 16'h0002, 3'b001);
		pin(4'h3, 1);
		pins("both edges", 16'h0002, 3'b001);
		pin(4'h2, 5);
		pins("down stop", 16'hFFFE, 3'b010);
		pin(4'h1, 2);
		pins("zero", 16'h0000, 3'b100);
	endtask

	task automatic t_ctrl();
		wr(`LUC_OFF_PRESET, 32'h1);
		pin(4'h8, 1);
		pins("preset", 16'h0001, 3'b000);
		pin(4'hD, 1);
		pins("clear wins", 16'h0000, 3'b100);
		wr(`LUC_OFF_LOWER, 32'h1);
		pin(4'h4, 1);
		pins("clear clamp", 16'h0001, 3'b010);
		wr(`LUC_OFF_LOWER, 32'h3);
		pin(4'h1, 1);
		pins("lower above upper", 16'h0002, 3'b001);
	endtask

	task automatic t_wrap();
		wr(`LUC_OFF_LOWER, 32'hFFFE);
		wr(`LUC_OFF_CTRL, 32'h1);
		wr(`LUC_OFF_PRESET, 32'h2);
		pin(4'h8, 1);
		wr(`LUC_OFF_IRQ_STAT, 32'h7);
		rd("stat clear", `LUC_OFF_IRQ_STAT, 32'h0);
		pin(4'h1, 1);
		pins("wrap up", 16'hFFFE, 3'b000);
		rd("stat over", `LUC_OFF_IRQ_STAT, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		pin(4'h2, 1);
		pins("wrap down", 16'h0002, 3'b000);
		rd("stat under", `LUC_OFF_IRQ_STAT, 32'h3);
		wr(`LUC_OFF_IRQ_MASK, 32'h2);
		@(posedge ref_clk);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(`LUC_OFF_IRQ_STAT, 32'h3);
		@(posedge ref_clk);
		chk("irq off", 32'h0, {31'h0, irq});
		rd("count reg", `LUC_OFF_COUNT, 32'h2);
	endtask

	// mid-run reset; up pin already high in the first pass, bounds valid by then
	task automatic t_restart();
		sysRst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		sysRst <= 1'b0;
		cmd <= 4'h1;
		wr(`LUC_OFF_UPPER, 32'h2);
		cmd <= 4'h0;
		repeat (6) @(posedge ref_clk);
		pins("first pass", 16'h0000, 3'b110);
		rd("wrap after reset", `LUC_OFF_CTRL, 32'h0);
		pin(4'h1, 1);
		pins("first edge", 16'h0001, 3'b000);
	endtask

	// divider 2: a pass every third cycle, pin levels still span one
	task automatic t_divider();
		int n;
		n = 0;
		wr(`LUC_OFF_PASS_DIV, 32'h2);
		rd("divider", `LUC_OFF_PASS_DIV, 32'h2);
		repeat (9)
		begin
			@(posedge ref_clk);
			if (tick === 1'b1)
				n++;
		end
		chk("ticks", 32'h3, 32'(n));
		pin(4'h1, 1);
		pins("slow pass", 16'h0002, 3'b001);
		wr(`LUC_OFF_PASS_DIV, 32'h0);
	endtask

	initial
	begin
		repeat (5) @(posedge ref_clk);
		sysRst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		t_reset();
		t_count();
		t_ctrl();
		t_wrap();
		t_restart();
		t_divider();
		print_verdict();
	end

	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errCount++;
		print_verdict();
	end
endmodule

`default_nettype wire
